//--- test/hwrc_chk_properties.sv
// Port checker for the halt, wake-up and reset sequencer
`timescale 1ns/10ps
module hwrc_chk #(
   parameter SST = 1024
) (
   // Clock and reset
   input logic       core_clk,
   input logic       rst_b,
   input logic       clk_en,
   // Events
   input logic       halt_instr,
   input logic       clear_watchdog_instr,
   input logic       external_reset_pin_b,
   input logic       usb_bus_reset,
   input logic       watchdog_overflow,
   input logic       watchdog_rc_sel,
   // Outputs
   input logic       sys_osc_en_q,
   input logic       watchdog_osc_en_q,
   input logic       watchdog_clear_q,
   input logic       core_hold_q,
   input logic       chip_reset_q,
   input logic       warm_reset_q,
   input logic       resume_next_q,
   input logic       int_take_q,
   input logic       io_hold_q,
   input logic       timeout_flag_q,
   input logic       power_down_flag_q,
   input logic [2:0] reset_cause_q
);
   // Bound suits the shortened start-up count only
   localparam int REL_MAX = 40;
   logic quiet;
   assign quiet = clk_en && !core_hold_q && !chip_reset_q
      && external_reset_pin_b && !usb_bus_reset && !watchdog_overflow;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Sequences
   sequence halt_taken;
      quiet && halt_instr;
   endsequence
   sequence wake_start;
      $rose(sys_osc_en_q);
   endsequence
   // ==========================================
   // Properties
   halt_flags_a: assert property (
      halt_taken |=> power_down_flag_q && !timeout_flag_q)
      else $error("halt left wrong flags");
   halt_stop_a: assert property (
      halt_taken |=> !sys_osc_en_q && core_hold_q && io_hold_q)
      else $error("halt did not stop and freeze");
   wdt_restart_a: assert property (
      halt_taken ##0 watchdog_rc_sel |=> watchdog_clear_q && watchdog_osc_en_q)
      else $error("watchdog not restarted on halt");
   pdf_clear_a: assert property (
      quiet && clear_watchdog_instr && !halt_instr |=> !power_down_flag_q)
      else $error("power-down flag not cleared");
   pdf_source_a: assert property (
      $rose(power_down_flag_q) |-> $past(halt_instr))
      else $error("power-down flag set without halt");
   wake_dwell_a: assert property (
      wake_start |-> core_hold_q [*8])
      else $error("core released too early");
   wake_bound_a: assert property (
      wake_start |-> ##[1:REL_MAX] !core_hold_q)
      else $error("core not released");
   pulse_edge_a: assert property (
      resume_next_q || int_take_q || warm_reset_q |-> $fell(core_hold_q))
      else $error("release pulse off the release edge");
   one_cause_a: assert property (
      $onehot0({resume_next_q, int_take_q, warm_reset_q}))
      else $error("two release pulses at once");
   warm_keep_a: assert property (
      warm_reset_q |-> timeout_flag_q && power_down_flag_q && !chip_reset_q
         && reset_cause_q == 3'h4)
      else $error("warm reset state wrong");
   run_wdt_a: assert property (
      clk_en && watchdog_overflow && !core_hold_q && !chip_reset_q
         |-> ##[1:2] (chip_reset_q && timeout_flag_q))
      else $error("run overflow did not reset");
endmodule // hwrc_chk
bind hwrc_ctrl hwrc_chk #(.SST(SST)) i_chk (.*);

//--- test/hwrc_far_model.sv
// Stand-in for the core, the reset pin and port A
`timescale 1ns/10ps
module hwrc_far_model (
   // Clock
   input  logic       core_clk,
   // Core instruction strobes
   output logic       halt_instr,
   output logic       clear_watchdog_instr,
   // Pulled-high pins
   output logic       external_reset_pin_b,
   output logic [7:0] port_a_in
);
   initial begin
      halt_instr = 1'b0;
      clear_watchdog_instr = 1'b0;
      external_reset_pin_b = 1'b1;
      port_a_in = 8'hFF;
   end
   // One-cycle strobe between falling edges
   task automatic exec(input logic halt);
      @(negedge core_clk);
      halt_instr = halt;
      clear_watchdog_instr = !halt;
      @(negedge core_clk);
      halt_instr = 1'b0;
      clear_watchdog_instr = 1'b0;
   endtask
   task automatic drop(input int n);
      @(negedge core_clk);
      port_a_in[n] = 1'b0;
   endtask
   // Released pins go back to the pull-up level
   task automatic rel();
      @(negedge core_clk);
      port_a_in = 8'hFF;
   endtask
   task automatic pin_reset();
      @(negedge core_clk);
      external_reset_pin_b = 1'b0;
      repeat (2) @(negedge core_clk);
      external_reset_pin_b = 1'b1;
   endtask
endmodule // hwrc_far_model

//--- test/tb.sv
// Self-checking bench for the halt, wake-up and reset sequencer
`timescale 1ns/10ps
module tb;
   localparam int SST = 8;
   int         err_count = 0;
   int         total_checks = 0;
   logic       core_clk, rst_b, clk_en, stack_full, int_global_en;
   logic [5:0] int_req, int_en;
   logic       usb_bus_reset, watchdog_overflow, watchdog_rc_sel;
   logic [7:0] port_a_wake_en;
   // Case bits: source enable, global enable, stack full, release pulse
   logic [5:0] icase [4] = '{6'b110010, 6'b111100, 6'b100100,
      6'b010100};
   wire        halt_instr, clear_watchdog_instr, external_reset_pin_b;
   wire [7:0]  port_a_in;
   wire        sys_osc_en_q, watchdog_osc_en_q, watchdog_clear_q;
   wire        core_hold_q, chip_reset_q, warm_reset_q, resume_next_q;
   wire        int_take_q, io_hold_q, timeout_flag_q, power_down_flag_q;
   wire [2:0]  reset_cause_q;
   wire [7:0]  st = {timeout_flag_q, power_down_flag_q, sys_osc_en_q,
      core_hold_q, io_hold_q, chip_reset_q, watchdog_clear_q,
      watchdog_osc_en_q};
   hwrc_ctrl #(.SST(SST)) i_dut (.*);
   hwrc_far_model i_far (.*);
   // ==========================================
   // Checking tasks
   task automatic chk(input string name, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic flags(input logic [1:0] tp, input logic [2:0] c);
      chk("flags", {3'h0, timeout_flag_q, power_down_flag_q, reset_cause_q},
         {3'h0, tp, c});
   endtask
   // Bounded wait for release, then dwell and release pulse
   task automatic free(input logic [2:0] pls);
      int n;
      n = 0;
      while (core_hold_q !== 1'b0 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 60) begin
         chk("release", 8'h0, 8'h1);
         complete_run();
      end
      chk("dwell", 8'(n >= SST - 4 && n <= SST + 8), 8'h1);
      chk("pulse", {5'h0, resume_next_q, int_take_q, warm_reset_q}, {5'h0, pls});
   endtask
   // ==========================================
   // Clock and sequence
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      stack_full = 1'b0;
      int_global_en = 1'b1;
      int_req = 6'h00;
      int_en = 6'h3F;
      usb_bus_reset = 1'b0;
      watchdog_overflow = 1'b0;
      watchdog_rc_sel = 1'b1;
      port_a_wake_en = 8'h00;
      repeat (16) @(negedge core_clk);
      chk("reset", st, 8'h37);
      flags(2'b00, 3'h0);
      rst_b = 1'b1;
      free(3'b000);
      // Halt strobe while frozen must leave every output alone
      clk_en = 1'b0;
      i_far.exec(1'b1);
      chk("frozen", st, 8'h21);
      clk_en = 1'b1;
      port_a_wake_en = 8'h0F;
      i_far.exec(1'b1);
      chk("halt", st, 8'h5B);
      i_far.drop(7);
      repeat (20) @(negedge core_clk);
      chk("masked", st & 8'h30, 8'h10);
      i_far.drop(1);
      free(3'b100);
      i_far.rel();
      i_far.exec(1'b0);
      chk("clear", {7'h0, power_down_flag_q}, 8'h00);
      foreach (icase[i]) begin
         int_en = {3'h7, icase[i][5], 2'h3};
         int_global_en = icase[i][4];
         stack_full = icase[i][3];
         i_far.exec(1'b1);
         int_req = 6'h04;
         free(icase[i][2:0]);
         int_req = 6'h00;
      end
      int_req = 6'h08;
      i_far.exec(1'b1);
      repeat (20) @(negedge core_clk);
      chk("stale", st & 8'h30, 8'h10);
      watchdog_overflow = 1'b1;
      @(negedge core_clk);
      watchdog_overflow = 1'b0;
      free(3'b001);
      flags(2'b11, 3'h4);
      int_req = 6'h00;
      watchdog_overflow = 1'b1;
      @(negedge core_clk);
      watchdog_overflow = 1'b0;
      @(negedge core_clk);
      chk("wdt", {7'h0, chip_reset_q}, 8'h01);
      free(3'b000);
      flags(2'b11, 3'h3);
      i_far.exec(1'b0);
      i_far.pin_reset();
      free(3'b000);
      flags(2'b00, 3'h1);
      // Watchdog on instruction clock: no restart, its oscillator stops
      watchdog_rc_sel = 1'b0;
      i_far.exec(1'b1);
      chk("halt ic", st, 8'h58);
      watchdog_rc_sel = 1'b1;
      i_far.pin_reset();
      free(3'b000);
      flags(2'b01, 3'h2);
      usb_bus_reset = 1'b1;
      @(negedge core_clk);
      usb_bus_reset = 1'b0;
      free(3'b000);
      flags(2'b01, 3'h5);
      complete_run();
   end
endmodule // tb

//--- verilog/hwrc_ctrl.v
// Halt, wake-up and reset sequencing for a small microcontroller
`timescale 1ns/10ps
`include "hwrc_defs.vh"
module hwrc_ctrl #(
   parameter PW  = `HWRC_PORT_W,
   parameter NI  = 6,
   parameter SST = `HWRC_SST_CYCLES
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rst_b,
   input  wire          clk_en,
   // Core instruction events
   input  wire          halt_instr,
   input  wire          clear_watchdog_instr,
   input  wire          stack_full,
   input  wire          int_global_en,
   // Interrupt sources
   input  wire [NI-1:0] int_req,
   input  wire [NI-1:0] int_en,
   // External events
   input  wire          external_reset_pin_b,
   input  wire          usb_bus_reset,
   input  wire          watchdog_overflow,
   input  wire          watchdog_rc_sel,
   // Port A
   input  wire [PW-1:0] port_a_in,
   input  wire [PW-1:0] port_a_wake_en,
   // Oscillator and watchdog control
   output reg           sys_osc_en_q,
   output reg           watchdog_osc_en_q,
   output reg           watchdog_clear_q,
   // Core control
   output reg           core_hold_q,
   output reg           chip_reset_q,
   output reg           warm_reset_q,
   output reg           resume_next_q,
   output reg           int_take_q,
   output reg           io_hold_q,
   // Status flags
   output reg           timeout_flag_q,
   output reg           power_down_flag_q,
   output reg [2:0]     reset_cause_q
);
   reg [2:0]    state_q;
   reg [2:0]    state_d;
   reg [1:0]    wake_src_q;
   reg [NI-1:0] int_mask_q;
   reg          pin_q;
   reg          sst_start_q;
   wire         sst_done;
   wire         pin_wake;
   wire         pin_fall;
   wire         int_wake;
   wire         wdt_wake;
   wire         in_halt;

   assign in_halt  = (state_q == `HWRC_ST_HALT);
   assign pin_fall = pin_q & ~external_reset_pin_b;
   assign int_wake = in_halt & (|(int_req & ~int_mask_q));
   assign wdt_wake = in_halt & watchdog_overflow;

   // ==================================================================
   // Sub-blocks
   hwrc_wake #(.PW(PW)) u_wake (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .port_in  (port_a_in),
      .wake_en  (port_a_wake_en),
      .arm      (in_halt),
      .wake_q   (pin_wake)
   );

   hwrc_sst #(.CYCLES(SST)) u_sst (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .start    (sst_start_q),
      .done_q   (sst_done)
   );

   // Interrupt enabled and stack has room
   function int_vectors;
      input [NI-1:0] req;
      input [NI-1:0] en;
      input          gen;
      input          full;
      begin
         int_vectors = gen & ~full & (|(req & en));
      end
   endfunction

   // ==================================================================
   // Next state
   always @* begin
      state_d = state_q;
      case (state_q)
         `HWRC_ST_RUN: begin
            if (halt_instr) begin
               state_d = `HWRC_ST_HALT;
            end
         end
         `HWRC_ST_HALT: begin
            if (pin_wake | int_wake | wdt_wake) begin
               state_d = `HWRC_ST_DELAY;
            end
         end
         `HWRC_ST_DELAY: begin
            if (sst_done) begin
               state_d = `HWRC_ST_RUN;
            end
         end
         `HWRC_ST_RSTDLY: begin
            if (sst_done) begin
               state_d = `HWRC_ST_RUN;
            end
         end
         default: state_d = `HWRC_ST_RUN;
      endcase
      // Pin and USB resets override anything in flight
      if (pin_fall | usb_bus_reset) begin
         state_d = `HWRC_ST_RSTDLY;
      end else if (state_q == `HWRC_ST_RUN && watchdog_overflow) begin
         state_d = `HWRC_ST_RSTDLY;
      end
   end

   // ==================================================================
   // Sequencer
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q           <= `HWRC_ST_RSTDLY;
         wake_src_q        <= `HWRC_WAKE_NONE;
         int_mask_q        <= {NI{1'b0}};
         pin_q             <= 1'b1;
         sst_start_q       <= 1'b1;
         sys_osc_en_q      <= 1'b1;
         watchdog_osc_en_q <= 1'b1;
         watchdog_clear_q  <= 1'b1;
         core_hold_q       <= 1'b1;
         chip_reset_q      <= 1'b1;
         warm_reset_q      <= 1'b0;
         resume_next_q     <= 1'b0;
         int_take_q        <= 1'b0;
         io_hold_q         <= 1'b0;
         timeout_flag_q    <= 1'b0;
         power_down_flag_q <= 1'b0;
         reset_cause_q     <= `HWRC_CAUSE_POWERUP;
      end else if (clk_en) begin
         state_q          <= state_d;
         pin_q            <= external_reset_pin_b;
         sst_start_q      <= 1'b0;
         watchdog_clear_q <= 1'b0;
         warm_reset_q     <= 1'b0;
         resume_next_q    <= 1'b0;
         int_take_q       <= 1'b0;
         // Reset delay (power-up, pin, USB or run watchdog) holds reset until expiry, then releases
         if (state_q == `HWRC_ST_RSTDLY && sst_done) begin
            chip_reset_q <= 1'b0;
            core_hold_q  <= 1'b0;
         end
         if (state_q == `HWRC_ST_RUN && clear_watchdog_instr) begin
            timeout_flag_q    <= 1'b0;
            power_down_flag_q <= 1'b0;
            watchdog_clear_q  <= 1'b1;
         end
         if (state_q == `HWRC_ST_RUN && halt_instr) begin
            int_mask_q        <= int_req;
            power_down_flag_q <= 1'b1;
            timeout_flag_q    <= 1'b0;
            sys_osc_en_q      <= 1'b0;
            watchdog_osc_en_q <= watchdog_rc_sel;
            watchdog_clear_q  <= watchdog_rc_sel;
            core_hold_q       <= 1'b1;
            io_hold_q         <= 1'b1;
         end
         if (in_halt && state_d == `HWRC_ST_DELAY) begin
            sys_osc_en_q <= 1'b1;
            sst_start_q  <= 1'b1;
            if (wdt_wake) begin
               wake_src_q     <= `HWRC_WAKE_WDT;
               timeout_flag_q <= 1'b1;
            end else if (int_wake) begin
               wake_src_q <= `HWRC_WAKE_INT;
            end else begin
               wake_src_q <= `HWRC_WAKE_PIN;
            end
         end
         if (state_q == `HWRC_ST_DELAY && sst_done) begin
            core_hold_q <= 1'b0;
            io_hold_q   <= 1'b0;
            case (wake_src_q)
               `HWRC_WAKE_WDT: begin
                  warm_reset_q  <= 1'b1;
                  reset_cause_q <= `HWRC_CAUSE_WDT_HALT;
               end
               `HWRC_WAKE_INT: begin
                  if (int_vectors(int_req, int_en, int_global_en,
                                  stack_full)) begin
                     int_take_q <= 1'b1;
                  end else begin
                     resume_next_q <= 1'b1;
                  end
               end
               `HWRC_WAKE_PIN: resume_next_q <= 1'b1;
               default: resume_next_q <= 1'b1;
            endcase
         end
         // Chip resets: cause recorded, flags per cause
         if (pin_fall | usb_bus_reset |
             (state_q == `HWRC_ST_RUN && watchdog_overflow)) begin
            sst_start_q       <= 1'b1;
            chip_reset_q      <= 1'b1;
            core_hold_q       <= 1'b1;
            io_hold_q         <= 1'b0;
            sys_osc_en_q      <= 1'b1;
            watchdog_osc_en_q <= 1'b1;
            watchdog_clear_q  <= 1'b1;
            if (pin_fall && (in_halt || state_q == `HWRC_ST_DELAY)) begin
               timeout_flag_q    <= 1'b0;
               power_down_flag_q <= 1'b1;
               reset_cause_q     <= `HWRC_CAUSE_PIN_HALT;
            end else if (pin_fall) begin
               reset_cause_q <= `HWRC_CAUSE_PIN_RUN;
            end else if (usb_bus_reset) begin
               if (in_halt) begin
                  timeout_flag_q    <= 1'b0;
                  power_down_flag_q <= 1'b1;
               end
               reset_cause_q <= `HWRC_CAUSE_USB;
            end else begin
               timeout_flag_q <= 1'b1;
               reset_cause_q  <= `HWRC_CAUSE_WDT_RUN;
            end
         end
      end
   end
endmodule // hwrc_ctrl

//--- verilog/hwrc_defs.vh
// Constants for the halt, wake-up and reset control block
`ifndef HWRC_DEFS_VH
`define HWRC_DEFS_VH
`define HWRC_CLK_PERIOD_NS   8
`define HWRC_SST_CYCLES      1024
`define HWRC_SST_W           11
`define HWRC_PC_RESET        12'h000
`define HWRC_PC_W            12
`define HWRC_SP_W            4
`define HWRC_SP_TOP          4'h0
`define HWRC_PORT_W          8
`define HWRC_ST_RUN          3'h0
`define HWRC_ST_HALT         3'h1
`define HWRC_ST_DELAY        3'h2
`define HWRC_ST_RSTDLY       3'h3
`define HWRC_WAKE_NONE       2'h0
`define HWRC_WAKE_PIN        2'h1
`define HWRC_WAKE_INT        2'h2
`define HWRC_WAKE_WDT        2'h3
`define HWRC_CAUSE_POWERUP   3'h0
`define HWRC_CAUSE_PIN_RUN   3'h1
`define HWRC_CAUSE_PIN_HALT  3'h2
`define HWRC_CAUSE_WDT_RUN   3'h3
`define HWRC_CAUSE_WDT_HALT  3'h4
`define HWRC_CAUSE_USB       3'h5
`endif

//--- verilog/hwrc_sst.v
// Start-up delay timer counting system clocks
`timescale 1ns/10ps
`include "hwrc_defs.vh"
module hwrc_sst #(
   parameter CYCLES = `HWRC_SST_CYCLES,
   parameter CW     = `HWRC_SST_W
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rst_b,
   input  wire          clk_en,
   // Control
   input  wire          start,
   output reg           done_q
);
   reg [CW-1:0] count_q;
   reg          busy_q;

   // Restart on every start pulse, even mid-count
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= {CW{1'b0}};
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else if (clk_en) begin
         done_q <= 1'b0;
         if (start) begin
            count_q <= {CW{1'b0}};
            busy_q  <= 1'b1;
         end else if (busy_q) begin
            if (count_q == CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // hwrc_sst

//--- verilog/hwrc_wake.v
// Port A falling-edge wake detector with per-bit enable
`timescale 1ns/10ps
`include "hwrc_defs.vh"
module hwrc_wake #(
   parameter PW = `HWRC_PORT_W
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rst_b,
   input  wire          clk_en,
   // Port
   input  wire [PW-1:0] port_in,
   input  wire [PW-1:0] wake_en,
   input  wire          arm,
   output reg           wake_q
);
   reg [PW-1:0] prev_q;

   // Previous sample reloads every enabled cycle; edges wake only while armed
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= {PW{1'b1}};
         wake_q <= 1'b0;
      end else if (clk_en) begin
         prev_q <= port_in;
         wake_q <= arm & (|(prev_q & ~port_in & wake_en));
      end
   end
endmodule // hwrc_wake
